/* rtl/msac_pkg.sv */
package msac_pkg;

   // register byte offsets
   localparam logic [7:0]  STATUS_OFS   = 8'h00;
   localparam logic [7:0]  VERSION_OFS  = 8'h04;
   localparam logic [7:0]  CONFIG_OFS   = 8'h08;
   localparam logic [7:0]  IRQ_STAT_OFS = 8'h0c;
   localparam logic [7:0]  IRQ_MASK_OFS = 8'h10;

   // status word bit positions
   localparam int ST_REACT = 5;
   localparam int ST_ACT   = 4;
   localparam int ST_POW   = 3;
   localparam int ST_CUR   = 2;
   localparam int ST_SURGE = 1;
   localparam int ST_DIP   = 0;
   localparam int ST_W     = 6;

   // configuration word field positions
   localparam int CFG_GAIN2_LSB = 27;
   localparam int CFG_GAIN1_LSB = 24;
   localparam int CFG_TRIM_LSB  = 16;
   localparam int CFG_SRST_LSB  = 5;
   localparam int CFG_SHDN_LSB  = 3;

   // configuration reset values and gain code limits
   localparam logic [2:0]  GAIN_RST      = 3'h3;
   localparam logic [7:0]  TRIM_RST      = 8'h42;
   localparam logic [2:0]  GAIN_MAX_CODE = 3'h5;
   localparam logic [2:0]  GAIN_UNITY    = 3'h0;

   // interrupt bit positions
   localparam int IRQ_SURGE = 0;
   localparam int IRQ_DIP   = 1;
   localparam int IRQ_POW   = 2;
   localparam int IRQ_CUR   = 3;
   localparam int IRQ_W     = 4;

   localparam int ADC_W = 24;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic reactive_sign;
      logic active_sign;
      logic power_over;
      logic current_over;
      logic surge_det;
      logic dip_det;
   } msac_meas_t;

   typedef struct packed {
      logic [2:0] gain2;
      logic [2:0] gain1;
      logic [7:0] trim;
      logic [1:0] soft_rst;
      logic [1:0] shdn;
   } msac_cfg_t;

   typedef struct packed {
      logic [2:0] gain_exp;
      logic       bias_en;
      logic       clk_en;
      logic       dig_en;
   } msac_afe_t;

endpackage : msac_pkg

/* rtl/msac_regs.sv */
// Functional notes
// - status bit 5 shows channel-one reactive sign, one when inductive.
// - status bit 4 shows channel-one active sign, one when importing.
// - status bit 3 follows the channel-one over-power condition.
// - status bit 2 follows the channel-one over-current condition.
// - status bit 1 latches a surge detection until cleared.
// - status bit 0 latches a sag detection until cleared.
// - read-only fixed version word holds the engine date code.
// - each current channel takes gain from its own three-bit field.
// - gain codes zero to five give gains 1 to 32.
// - undefined gain codes 110 and 111 give unity gain.
// - soft reset entered only by writing the two-bit zero-force field.
// - in soft reset the converter runs but its result reads zero.
// - each converter powers down from its own shutdown bit only.
// - clearing a shutdown bit re-enables biases, clock and digital logic.
// - reference trim code resets to 0x42 until software changes it.
// - status word is read-only apart from clearing latched flags.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module msac_regs
   import msac_pkg::*;
#(
   parameter logic [15:0] DATE_CODE = 16'h1234 // arbitrary value
) (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // axi4-lite write address
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   // axi4-lite read data
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // measurement engine flags
   input  wire msac_pkg::msac_meas_t meas,
   // converter results
   input  wire logic [23:0]          adc_raw_ch1,
   input  wire logic [23:0]          adc_raw_ch2,
   output logic [23:0]               adc_out_ch1,
   output logic [23:0]               adc_out_ch2,
   // front-end controls
   output msac_pkg::msac_afe_t       afe_ch1,
   output msac_pkg::msac_afe_t       afe_ch2,
   // interrupt
   output logic                      irq
);

   // gain code to amplifier exponent, undefined codes give unity
   function automatic logic [2:0] gain_exp(input logic [2:0] code);
      if (code > GAIN_MAX_CODE) begin
         return GAIN_UNITY;
      end
      return code;
   endfunction : gain_exp

   // byte-lane merge of write data
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   localparam logic [31:0] CFG_RESET =
      (32'(GAIN_RST) << CFG_GAIN2_LSB) |
      (32'(GAIN_RST) << CFG_GAIN1_LSB) |
      (32'(TRIM_RST) << CFG_TRIM_LSB);

   // bus state
   logic              aw_hold_q;
   logic [7:0]        awaddr_q;
   logic              w_hold_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;

   // register state
   logic [ST_W-1:0]   status_q;
   logic [31:0]       cfg_word_q;
   logic [IRQ_W-1:0]  irq_stat_q;
   logic [IRQ_W-1:0]  irq_mask_q;
   msac_meas_t        meas_prev_q;
   logic [23:0]       adc_out_ch1_q;
   logic [23:0]       adc_out_ch2_q;
   msac_afe_t         afe_ch1_q;
   msac_afe_t         afe_ch2_q;

   msac_cfg_t         cfg;
   logic              wr_fire;
   logic              wr_status;
   logic              wr_cfg;
   logic              wr_istat;
   logic              wr_imask;
   logic [31:0]       wr_bits;
   logic              rd_fire;
   logic [IRQ_W-1:0]  irq_evt;

   assign cfg.gain2    = cfg_word_q[CFG_GAIN2_LSB +: 3];
   assign cfg.gain1    = cfg_word_q[CFG_GAIN1_LSB +: 3];
   assign cfg.trim     = cfg_word_q[CFG_TRIM_LSB +: 8];
   assign cfg.soft_rst = cfg_word_q[CFG_SRST_LSB +: 2];
   assign cfg.shdn     = cfg_word_q[CFG_SHDN_LSB +: 2];

   // write channel handshakes
   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_bits       = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                                     {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_status     = wr_fire && (awaddr_q == STATUS_OFS);
   assign wr_cfg        = wr_fire && (awaddr_q == CONFIG_OFS);
   assign wr_istat      = wr_fire && (awaddr_q == IRQ_STAT_OFS);
   assign wr_imask      = wr_fire && (awaddr_q == IRQ_MASK_OFS);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_q <= 1'b1;
         awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w_hold_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end
   end

   // write response, unmapped or read-only addresses still answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         if (wr_status || wr_cfg || wr_istat || wr_imask ||
             awaddr_q == VERSION_OFS) begin
            bresp_q <= RESP_OKAY;
         end else begin
            bresp_q <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // read channel
   assign s_axi_arready = !rvalid_q;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            STATUS_OFS:   rdata_q <= 32'(status_q);
            VERSION_OFS:  rdata_q <= 32'(DATE_CODE);
            CONFIG_OFS:   rdata_q <= cfg_word_q;
            IRQ_STAT_OFS: rdata_q <= 32'(irq_stat_q);
            IRQ_MASK_OFS: rdata_q <= 32'(irq_mask_q);
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // status word: live bits follow the engine, writes cannot set them
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= '0;
      end else begin
         status_q[ST_REACT] <= meas.reactive_sign;
         status_q[ST_ACT]   <= meas.active_sign;
         status_q[ST_POW]   <= meas.power_over;
         status_q[ST_CUR]   <= meas.current_over;
         // latched flags: detection wins over a same-cycle clear
         if (meas.surge_det) begin
            status_q[ST_SURGE] <= 1'b1;
         end else if (wr_status && wstrb_q[0] &&
                      !wdata_q[ST_SURGE]) begin
            status_q[ST_SURGE] <= 1'b0;
         end
         if (meas.dip_det) begin
            status_q[ST_DIP] <= 1'b1;
         end else if (wr_status && wstrb_q[0] &&
                      !wdata_q[ST_DIP]) begin
            status_q[ST_DIP] <= 1'b0;
         end
      end
   end

   // configuration word, only software writes change it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_word_q <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_word_q <= lane_merge(cfg_word_q, wdata_q, wstrb_q);
      end
   end

   // interrupt events on rising flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meas_prev_q <= '0;
      end else begin
         meas_prev_q <= meas;
      end
   end

   always_comb begin
      irq_evt            = '0;
      irq_evt[IRQ_SURGE] = meas.surge_det && !meas_prev_q.surge_det;
      irq_evt[IRQ_DIP]   = meas.dip_det && !meas_prev_q.dip_det;
      irq_evt[IRQ_POW]   = meas.power_over && !meas_prev_q.power_over;
      irq_evt[IRQ_CUR]   = meas.current_over && !meas_prev_q.current_over;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else if (wr_istat) begin
         irq_stat_q <= (irq_stat_q & ~wr_bits[IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_q <= irq_stat_q | irq_evt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_q <= '0;
      end else if (wr_imask && wstrb_q[0]) begin
         irq_mask_q <= wdata_q[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // converter results, forced to zero in soft reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         adc_out_ch1_q <= '0;
         adc_out_ch2_q <= '0;
      end else begin
         adc_out_ch1_q <= cfg.soft_rst[0] ? '0 : adc_raw_ch1;
         adc_out_ch2_q <= cfg.soft_rst[1] ? '0 : adc_raw_ch2;
      end
   end

   assign adc_out_ch1 = adc_out_ch1_q;
   assign adc_out_ch2 = adc_out_ch2_q;

   // front-end gain and power controls
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         afe_ch1_q <= '0;
         afe_ch2_q <= '0;
      end else begin
         afe_ch1_q.gain_exp <= gain_exp(cfg.gain1);
         afe_ch2_q.gain_exp <= gain_exp(cfg.gain2);
         afe_ch1_q.bias_en  <= !cfg.shdn[0];
         afe_ch1_q.clk_en   <= !cfg.shdn[0];
         afe_ch1_q.dig_en   <= !cfg.shdn[0];
         afe_ch2_q.bias_en  <= !cfg.shdn[1];
         afe_ch2_q.clk_en   <= !cfg.shdn[1];
         afe_ch2_q.dig_en   <= !cfg.shdn[1];
      end
   end

   assign afe_ch1 = afe_ch1_q;
   assign afe_ch2 = afe_ch2_q;

   // checks
   default clocking chk_cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_surge_set: assert property (
      meas.surge_det |=> status_q[ST_SURGE])
      else $error("surge flag not set");

   a_surge_hold: assert property (
      status_q[ST_SURGE] && !wr_status |=> status_q[ST_SURGE])
      else $error("surge flag dropped without clear");

   a_dip_clear: assert property (
      wr_status && wstrb_q[0] && !wdata_q[ST_DIP] && !meas.dip_det
      |=> !status_q[ST_DIP])
      else $error("dip flag not cleared by zero write");

   a_dip_set: assert property (
      meas.dip_det |=> status_q[ST_DIP])
      else $error("dip flag not set");

   a_sign_follow: assert property (
      ##1 status_q[ST_REACT] == $past(meas.reactive_sign) &&
      status_q[ST_ACT] == $past(meas.active_sign))
      else $error("sign bits do not follow engine");

   a_over_follow: assert property (
      ##1 status_q[ST_POW] == $past(meas.power_over) &&
      status_q[ST_CUR] == $past(meas.current_over))
      else $error("limit bits do not follow engine");

   a_version_read: assert property (
      rd_fire && s_axi_araddr[7:2] == VERSION_OFS[7:2]
      |=> s_axi_rvalid && s_axi_rdata == 32'(DATE_CODE))
      else $error("version word wrong");

   a_gain_undef: assert property (
      cfg.gain1 > GAIN_MAX_CODE |=> afe_ch1.gain_exp == GAIN_UNITY)
      else $error("undefined gain not unity");

   a_gain_map: assert property (
      cfg.gain2 <= GAIN_MAX_CODE |=> afe_ch2.gain_exp == $past(cfg.gain2))
      else $error("gain code not passed through");

   a_cfg_stable: assert property (
      !wr_cfg |=> $stable(cfg_word_q))
      else $error("configuration changed without write");

   a_soft_zero: assert property (
      cfg.soft_rst[0] |=> adc_out_ch1 == '0)
      else $error("soft reset result not zero");

   a_shdn_wake: assert property (
      $fell(cfg.shdn[1]) |=> afe_ch2.bias_en && afe_ch2.clk_en &&
      afe_ch2.dig_en)
      else $error("converter not woken");

   a_shdn_off: assert property (
      cfg.shdn[0] |=> !afe_ch1.bias_en)
      else $error("biases on in shutdown");

   c_surge_latch: cover property (
      meas.surge_det ##1 !meas.surge_det ##1 status_q[ST_SURGE]);
   c_flag_clear: cover property (status_q[ST_DIP] ##1 !status_q[ST_DIP]);
   c_soft_reset: cover property ($rose(cfg.soft_rst[0]));
   c_irq_raise: cover property ($rose(irq));

endmodule : msac_regs

`default_nettype wire

/* bench/msac_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
   n_compared++; \
   if ((a) !== (b)) begin \
      err_total++; \
      $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
   end \
end

module msac_regs_test;
   import msac_pkg::*;

   localparam logic [15:0] DATE    = 16'h5a3c; // arbitrary value
   localparam logic [31:0] CFG_DEF = 32'h1b420000;

   typedef struct packed {
      logic [5:0] m;
      logic [2:0] g1;
      logic [2:0] g2;
      logic [7:0] st;
      logic [2:0] e1;
      logic [2:0] e2;
   } msac_row_t;

   logic        clk_sys;
   logic        rst_n;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   msac_meas_t  meas;
   logic [23:0] raw1;
   logic [23:0] raw2;
   logic [23:0] out1;
   logic [23:0] out2;
   msac_afe_t   afe1;
   msac_afe_t   afe2;
   logic        irq;
   logic [1:0]  resp;
   int          err_total;
   int          n_compared;
   int          cyc = 0;

   // gain codes 0..7 on ch1, reversed on ch2, with live status flags
   msac_row_t rows [8] = '{
      '{6'h20, 3'h0, 3'h7, 8'h20, 3'h0, 3'h0},
      '{6'h10, 3'h1, 3'h6, 8'h10, 3'h1, 3'h0},
      '{6'h08, 3'h2, 3'h5, 8'h08, 3'h2, 3'h5},
      '{6'h04, 3'h3, 3'h4, 8'h04, 3'h3, 3'h4},
      '{6'h30, 3'h4, 3'h3, 8'h30, 3'h4, 3'h3},
      '{6'h0c, 3'h5, 3'h2, 8'h0c, 3'h5, 3'h2},
      '{6'h00, 3'h6, 3'h1, 8'h00, 3'h0, 3'h1},
      '{6'h3c, 3'h7, 3'h0, 8'h3c, 3'h0, 3'h0}
   };

   msac_regs #(.DATE_CODE(DATE)) i_dut (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .s_axi_awaddr  (awaddr),
      .s_axi_awvalid (awvalid),
      .s_axi_awready (awready),
      .s_axi_wdata   (wdata),
      .s_axi_wstrb   (wstrb),
      .s_axi_wvalid  (wvalid),
      .s_axi_wready  (wready),
      .s_axi_bresp   (bresp),
      .s_axi_bvalid  (bvalid),
      .s_axi_bready  (bready),
      .s_axi_araddr  (araddr),
      .s_axi_arvalid (arvalid),
      .s_axi_arready (arready),
      .s_axi_rdata   (rdata),
      .s_axi_rresp   (rresp),
      .s_axi_rvalid  (rvalid),
      .s_axi_rready  (rready),
      .meas          (meas),
      .adc_raw_ch1   (raw1),
      .adc_raw_ch2   (raw2),
      .adc_out_ch1   (out1),
      .adc_out_ch2   (out2),
      .afe_ch1       (afe1),
      .afe_ch2       (afe2),
      .irq           (irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic note(input string s);
      $display("test %s done", s);
   endtask : note

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad = 1'b0;
      logic dd = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clk_sys);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!dd && wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      resp = rresp;
      rready <= 1'b0;
      `CHK(rdata, e)
   endtask : rchk

   // latch pulse on the measurement flags for one cycle
   task automatic pulse(input logic [5:0] m);
      meas <= m;
      tick(1);
      meas <= 6'h00;
      tick(2);
   endtask : pulse

   initial begin
      rst_n = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      meas = '0;
      raw1 = 24'habcdef;
      raw2 = 24'h13579b;
      err_total = 0;
      n_compared = 0;
      tick(4);
      `CHK(afe1, 6'h00)
      `CHK(afe2, 6'h00)
      `CHK(out2, 24'h0)
      `CHK(irq, 1'b0)
      rst_n <= 1'b1;
      tick(1);
      rchk(CONFIG_OFS, CFG_DEF);
      `CHK(resp, RESP_OKAY)
      rchk(VERSION_OFS, {16'h0, DATE});
      wr(VERSION_OFS, 32'h0000ffff);
      `CHK(resp, RESP_OKAY)
      rchk(VERSION_OFS, {16'h0, DATE});
      note("reset and version");
      foreach (rows[i]) begin
         meas <= rows[i].m;
         wr(CONFIG_OFS, {2'b00, rows[i].g2, rows[i].g1, 8'h42, 16'h0});
         tick(2);
         `CHK(afe1, {rows[i].e1, 3'b111})
         `CHK(afe2, {rows[i].e2, 3'b111})
         rchk(STATUS_OFS, {24'h0, rows[i].st});
         `CHK(irq, 1'b0)
      end
      note("status and gain table");
      pulse(6'h02);
      rchk(STATUS_OFS, 32'h02);
      pulse(6'h01);
      rchk(STATUS_OFS, 32'h03);
      wstrb <= 4'he;
      wr(STATUS_OFS, 32'h00);
      wstrb <= 4'hf;
      rchk(STATUS_OFS, 32'h03);
      wr(STATUS_OFS, 32'h3d);
      rchk(STATUS_OFS, 32'h01);
      wr(STATUS_OFS, 32'h00);
      rchk(STATUS_OFS, 32'h00);
      note("latched flags");
      wr(CONFIG_OFS, CFG_DEF | 32'h20);
      tick(2);
      `CHK(out1, 24'h0)
      `CHK(out2, raw2)
      `CHK(afe1, 6'h1f)
      wr(CONFIG_OFS, CFG_DEF | 32'h40);
      tick(2);
      `CHK(out1, raw1)
      `CHK(out2, 24'h0)
      note("soft reset");
      wr(CONFIG_OFS, CFG_DEF | 32'h08);
      tick(2);
      `CHK(afe1, 6'h18)
      `CHK(afe2, 6'h1f)
      wr(CONFIG_OFS, CFG_DEF | 32'h10);
      tick(2);
      `CHK(afe1, 6'h1f)
      `CHK(afe2, 6'h18)
      note("shutdown");
      wr(IRQ_STAT_OFS, 32'hf);
      rchk(IRQ_STAT_OFS, 32'h0);
      wr(IRQ_MASK_OFS, 32'h1);
      pulse(6'h02);
      `CHK(irq, 1'b1)
      rchk(IRQ_STAT_OFS, 32'h1);
      wr(IRQ_MASK_OFS, 32'h2);
      tick(2);
      `CHK(irq, 1'b0)
      wr(IRQ_MASK_OFS, 32'h1);
      tick(2);
      `CHK(irq, 1'b1)
      wr(IRQ_STAT_OFS, 32'h1);
      tick(2);
      `CHK(irq, 1'b0)
      note("interrupt");
      wr(8'h20, 32'h1);
      `CHK(resp, RESP_SLVERR)
      rchk(8'h20, 32'h0);
      `CHK(resp, RESP_SLVERR)
      note("unmapped");
      wr(CONFIG_OFS, 32'h1b550000);
      rchk(CONFIG_OFS, 32'h1b550000);
      rst_n <= 1'b0;
      tick(4);
      `CHK(out1, 24'h0)
      rst_n <= 1'b1;
      tick(1);
      rchk(CONFIG_OFS, CFG_DEF);
      note("trim and second reset");
      conclude();
   end

endmodule : msac_regs_test
`undef CHK
`default_nettype wire
